// ### hdl/mceb_pkg.sv
// What this block does
// - capability register at 0179H reports bank count in bits 7:0.
// - bank zero control register sits at 400H, start of bank space.
// - control holds 64 enable flags; set flag lets uncorrected error raise exception.
// - detected errors are logged regardless of enable flags; one arriving over a kept log only sets overflow and, if corrected, bumps the count.
// - writes to unimplemented enable bits are dropped; they read as zero.
// - status cleared by writing zeros; any one bit raises protection fault.
// - status meaningful only while valid bit 63 set; set on logging.
// - status bits 15:0 carry architectural error code.
// - status bits 31:16 carry model error code.
// - bits 37:32 other info; with firmware-first, bit 37 is firmware-edited flag.
// - capability bit 10 clear: bits 52:38 are implementation info.
// - capability bit 10 set: bits 52:38 count corrected errors until cleared.
// - bit 52 is sticky count overflow until software clears.
// - capability bit 11 selects architectural meaning of bits 56:53.
// - with bit 11 set, bit 24 clear makes 56:55 reserved, set makes them flags.
// - with recovery support, bit 56 marks uncorrected recoverable error.
// - with recovery support, bit 55 marks software recovery action needed.
// - bits 54:53 give threshold status only for corrected errors.
// - bits 57..62: context corrupt, addr valid, misc valid, enabled, uncorrected, overflow.
// - overflow set when new error arrives over a valid log, unless a zero status write clears it in that cycle.
// - threshold code 00 none, 01 green, 10 yellow, 11 reserved.
package mceb_pkg;
    localparam logic [31:0] CAP_ADDR     = 32'h0000_0179;
    localparam logic [31:0] BANK0_CTL    = 32'h0000_0400;
    localparam logic [31:0] BANK0_STATUS = 32'h0000_0401;
    localparam logic [7:0]  BANK_COUNT   = 8'h01;
    localparam int          CAP_CNT_LSB  = 0;
    localparam int          CAP_CMCI_BIT = 10;
    localparam int          CAP_TES_BIT  = 11;
    localparam int          CAP_SER_BIT  = 24;
    localparam int          CAP_EMC_BIT  = 25;
    localparam int          ST_VALID     = 63;
    localparam int          ST_OVER      = 62;
    localparam int          ST_UNCORR    = 61;
    localparam int          ST_EN        = 60;
    localparam int          ST_EXTRA_OK  = 59;
    localparam int          ST_ADDR_OK   = 58;
    localparam int          ST_CORRUPT   = 57;
    localparam int          ST_SIGNAL    = 56;
    localparam int          ST_ACTION    = 55;
    localparam int          ST_THR_LSB   = 53;
    localparam int          ST_CNT_LSB   = 38;
    localparam int          ST_FWED      = 37;
    localparam int          ST_OTH_LSB   = 32;
    localparam int          ST_MODEL_LSB = 16;
    localparam logic [14:0] CNT_MAX      = 15'h3fff;
    localparam logic [1:0]  THR_NONE     = 2'h0;
    localparam logic [1:0]  THR_GREEN    = 2'h1;
    localparam logic [1:0]  THR_YELLOW   = 2'h2;
    localparam logic [1:0]  THR_RSVD     = 2'h3;

    typedef struct packed {
        logic        uncorrected_flag;
        logic        context_corrupt_flag;
        logic        address_register_valid;
        logic        extra_info_valid;
        logic        uncorrected_recoverable;
        logic        recovery_action_needed;
        logic        firmware_edited;
        logic [1:0]  threshold;
        logic [5:0]  errorIndex;
        logic [5:0]  otherInfo;
        logic [14:0] modelInfo;
        logic [3:0]  extInfo;
        logic [15:0] model_error_code;
        logic [15:0] archCode;
    } mceb_report_t;

    typedef enum logic [1:0] {
        ACC_IDLE  = 2'b00,
        ACC_READ  = 2'b01,
        ACC_WRITE = 2'b10
    } mceb_acc_t;
endpackage

// ### hdl/mceb_bank.sv
`timescale 1ns/10ps
module mceb_bank #(
    parameter logic [63:0] IMPL_MASK = 64'hffff_ffff_ffff_ffff,
    parameter logic [63:0] CAP_VALUE = 64'h0000_0000_0300_0c01
) (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire mceb_pkg::mceb_acc_t   acc,
    input  wire logic [31:0]           addr,
    input  wire logic [63:0]           wdata,
    input  wire logic                  errValid,
    input  wire mceb_pkg::mceb_report_t errReport,
    output logic [63:0]                rdata_q,
    output logic                       ack_q,
    output logic                       gpFault_q,
    output logic                       machine_check_exception_q
);
    logic [63:0] ctl_q,  ctl_d;
    logic [63:0] stat_q, stat_d;
    logic [14:0] cnt_q,  cnt_d;
    logic [63:0] rdata_d;
    logic        ack_d, gp_d, mce_d;
    logic        isCtl, isStat, isCap, zeroWr, enHit, keepOld, cntArch;
    logic [63:0] fresh;
    logic [1:0]  thr;

    assign cntArch = CAP_VALUE[mceb_pkg::CAP_CMCI_BIT];

    always_comb begin
        isCap  = addr == mceb_pkg::CAP_ADDR;
        isCtl  = addr == mceb_pkg::BANK0_CTL;
        isStat = addr == mceb_pkg::BANK0_STATUS;
        zeroWr = acc == mceb_pkg::ACC_WRITE && isStat && wdata == 64'h0;
        enHit  = ctl_q[errReport.errorIndex];
        // corrected threshold only; uncorrected leaves it undefined, so zero
        thr = errReport.uncorrected_flag ? 2'h0 : errReport.threshold;
        if (thr == mceb_pkg::THR_RSVD) begin
            thr = mceb_pkg::THR_NONE;
        end
        fresh = 64'h0;
        fresh[15:0]  = errReport.archCode;
        fresh[31:16] = errReport.model_error_code;
        fresh[36:32] = errReport.otherInfo[4:0];
        fresh[mceb_pkg::ST_FWED] = CAP_VALUE[mceb_pkg::CAP_EMC_BIT]
                                   ? errReport.firmware_edited
                                   : errReport.otherInfo[5];
        fresh[52:38] = cntArch ? 15'h0 : errReport.modelInfo;
        if (CAP_VALUE[mceb_pkg::CAP_TES_BIT]) begin
            fresh[54:53] = thr;
            if (CAP_VALUE[mceb_pkg::CAP_SER_BIT]) begin
                fresh[mceb_pkg::ST_SIGNAL] = errReport.uncorrected_recoverable;
                fresh[mceb_pkg::ST_ACTION] = errReport.recovery_action_needed;
            end
        end else begin
            fresh[56:53] = errReport.extInfo;
        end
        fresh[mceb_pkg::ST_CORRUPT]  = errReport.context_corrupt_flag;
        fresh[mceb_pkg::ST_ADDR_OK]  = errReport.address_register_valid;
        fresh[mceb_pkg::ST_EXTRA_OK] = errReport.extra_info_valid;
        fresh[mceb_pkg::ST_EN]     = enHit;
        fresh[mceb_pkg::ST_UNCORR] = errReport.uncorrected_flag;
        fresh[mceb_pkg::ST_VALID]  = 1'b1;
        // uncorrected never overwrites a valid uncorrected; yellow beats green
        keepOld = stat_q[mceb_pkg::ST_VALID] &&
                  (stat_q[mceb_pkg::ST_UNCORR] ||
                   (!errReport.uncorrected_flag &&
                    stat_q[54:53] == mceb_pkg::THR_YELLOW &&
                    thr != mceb_pkg::THR_YELLOW));
    end

    always_comb begin
        ctl_d   = ctl_q;
        stat_d  = stat_q;
        cnt_d   = cnt_q;
        rdata_d = rdata_q;
        ack_d   = 1'b0;
        gp_d    = 1'b0;
        mce_d   = 1'b0;
        case (acc)
            mceb_pkg::ACC_READ: begin
                ack_d = 1'b1;
                if (isCap) begin
                    rdata_d = CAP_VALUE;
                end else if (isCtl) begin
                    rdata_d = ctl_q;
                end else if (isStat) begin
                    rdata_d = stat_q;
                    if (cntArch) begin
                        rdata_d[52:38] = cnt_q;
                    end
                end else begin
                    rdata_d = 64'h0;
                    gp_d    = 1'b1;
                end
            end
            mceb_pkg::ACC_WRITE: begin
                ack_d = 1'b1;
                if (isCtl) begin
                    ctl_d = wdata & IMPL_MASK;
                end else if (zeroWr) begin
                    stat_d = 64'h0;
                    cnt_d  = 15'h0;
                end else begin
                    gp_d = 1'b1;
                end
            end
            default: begin
            end
        endcase
        // logging wins over a same-cycle clear so no error is lost
        if (errValid) begin
            // a same-cycle clear empties the bank, so the new log stands alone
            if (!keepOld || zeroWr) begin
                stat_d = fresh;
            end
            if (stat_q[mceb_pkg::ST_VALID] && !zeroWr) begin
                stat_d[mceb_pkg::ST_OVER] = 1'b1;
            end
            if (cntArch && !errReport.uncorrected_flag) begin
                cnt_d = (zeroWr ? 15'h0 : cnt_q) + 15'h1;
                if ((cnt_q & mceb_pkg::CNT_MAX) == mceb_pkg::CNT_MAX && !zeroWr) begin
                    cnt_d[14] = 1'b1;
                end
                if (cnt_q[14] && !zeroWr) begin
                    cnt_d[14] = 1'b1;
                end
            end
            mce_d = enHit && errReport.uncorrected_flag;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_q   <= 64'h0;
            stat_q  <= 64'h0;
            cnt_q   <= 15'h0;
            rdata_q <= 64'h0;
            ack_q   <= 1'b0;
            gpFault_q <= 1'b0;
            machine_check_exception_q <= 1'b0;
        end else begin
            ctl_q   <= ctl_d;
            stat_q  <= stat_d;
            cnt_q   <= cnt_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            gpFault_q <= gp_d;
            machine_check_exception_q <= mce_d;
        end
    end
endmodule

// ### tb/mceb_bank_properties.sv
`timescale 1ns/10ps
module mceb_bank_properties #(
    parameter logic [63:0] IMPL_MASK = 64'hffff_ffff_ffff_ffff,
    parameter logic [63:0] CAP_VALUE = 64'h0000_0000_0300_0c01
) (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire mceb_pkg::mceb_acc_t    acc,
    input wire logic [31:0]            addr,
    input wire logic [63:0]            wdata,
    input wire logic                   errValid,
    input wire mceb_pkg::mceb_report_t errReport,
    input wire logic [63:0]            rdata_q,
    input wire logic                   ack_q,
    input wire logic                   gpFault_q,
    input wire logic                   machine_check_exception_q
);
    wire logic isWr = acc == mceb_pkg::ACC_WRITE;
    wire logic isRd = acc == mceb_pkg::ACC_READ;
    wire logic isSt = addr == mceb_pkg::BANK0_STATUS;
    wire logic isCtl = addr == mceb_pkg::BANK0_CTL;
    wire logic isCap = addr == mceb_pkg::CAP_ADDR;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_ctl_ok; (isWr || isRd) && isCtl |=> ack_q && !gpFault_q; endproperty
    a_ctl_ok: assert property (p_ctl_ok) else $error("control access refused");
    property p_cap; isRd && isCap |=> rdata_q == CAP_VALUE && rdata_q[7:0] != 8'h0; endproperty
    a_cap: assert property (p_cap) else $error("capability read wrong");
    property p_cap_ro; isWr && isCap |=> ack_q && gpFault_q; endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capability write accepted");
    property p_mask; isRd && isCtl |=> (rdata_q & ~IMPL_MASK) == 64'h0; endproperty
    a_mask: assert property (p_mask) else $error("unimplemented enable bit set");
    property p_st_gp; isWr && isSt && wdata != 64'h0 |=> ack_q && gpFault_q; endproperty
    a_st_gp: assert property (p_st_gp) else $error("nonzero status write no fault");
    property p_st_clr; isWr && isSt && wdata == 64'h0 |=> ack_q && !gpFault_q; endproperty
    a_st_clr: assert property (p_st_clr) else $error("zero status write faulted");
    property p_mce;
        machine_check_exception_q |-> $past(errValid) && $past(errReport.uncorrected_flag);
    endproperty
    a_mce: assert property (p_mce) else $error("exception without uncorrected error");
    property p_unmap; isRd && !isSt && !isCtl && !isCap |=> gpFault_q && rdata_q == 64'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    property p_idle; acc == mceb_pkg::ACC_IDLE |=> !ack_q && !gpFault_q; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
endmodule
bind mceb_bank mceb_bank_properties #(.IMPL_MASK(IMPL_MASK), .CAP_VALUE(CAP_VALUE)) chk_u (
    .clk(clk), .srst(srst), .acc(acc), .addr(addr), .wdata(wdata), .errValid(errValid),
    .errReport(errReport), .rdata_q(rdata_q), .ack_q(ack_q), .gpFault_q(gpFault_q),
    .machine_check_exception_q(machine_check_exception_q));

// ### tb/mceb_bank_test.sv
`timescale 1ns/10ps
module mceb_bank_test;
    localparam logic [63:0] MASK = 64'h00ff_ffff_ffff_ffff;
    localparam logic [63:0] CAPV = 64'h0000_0000_0300_0c01;
    logic                   clk = 1'b0;
    logic                   srst = 1'b1;
    mceb_pkg::mceb_acc_t    acc = mceb_pkg::ACC_IDLE;
    logic [31:0]            addr = 32'h0;
    logic [63:0]            wdata = 64'h0;
    logic                   errValid = 1'b0;
    mceb_pkg::mceb_report_t errReport = '0;
    logic [63:0]            rdata_q;
    logic                   ack_q;
    logic                   gpFault_q;
    logic                   mce_q;
    logic [63:0]            rd;
    int                     err_count = 0;
    int                     samples_checked = 0;
    always #12.5 clk = ~clk;
    mceb_bank #(.IMPL_MASK(MASK), .CAP_VALUE(CAPV)) dut_u (
        .clk(clk), .srst(srst), .acc(acc), .addr(addr), .wdata(wdata), .errValid(errValid),
        .errReport(errReport), .rdata_q(rdata_q), .ack_q(ack_q), .gpFault_q(gpFault_q),
        .machine_check_exception_q(mce_q));
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic access(input mceb_pkg::mceb_acc_t k, input logic [31:0] a,
                          input logic [63:0] d, input logic gp);
        @(negedge clk);
        acc = k;
        addr = a;
        wdata = d;
        @(negedge clk);
        acc = mceb_pkg::ACC_IDLE;
        chk("ack", {63'h0, ack_q}, 64'h1);
        chk("fault", {63'h0, gpFault_q}, {63'h0, gp});
        rd = rdata_q;
    endtask
    task automatic inject(input logic unc, input logic [5:0] idx, input logic mce);
        @(negedge clk);
        errValid = 1'b1;
        errReport.uncorrected_flag = unc;
        errReport.context_corrupt_flag = unc;
        errReport.uncorrected_recoverable = unc;
        errReport.recovery_action_needed = unc;
        errReport.errorIndex = idx;
        @(negedge clk);
        errValid = 1'b0;
        chk("exception", {63'h0, mce_q}, {63'h0, mce});
    endtask
    // uncorrected errors carry no threshold colour
    function automatic logic [63:0] exp_st(logic unc, logic en, logic ov, logic [14:0] cnt);
        return {1'b1, ov, unc, en, 1'b0, 1'b1, unc, unc, unc, unc ? 2'h0 : mceb_pkg::THR_GREEN,
                cnt, 1'b1, 5'h05, 16'h1234, 16'h0abc};
    endfunction
    task automatic status(input string what, input logic [63:0] exp);
        access(mceb_pkg::ACC_READ, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        chk(what, rd, exp);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end
    initial begin
        errReport.address_register_valid = 1'b1;
        errReport.firmware_edited = 1'b1;
        errReport.threshold = mceb_pkg::THR_GREEN;
        errReport.otherInfo = 6'h05;
        errReport.modelInfo = 15'h7fff;
        errReport.extInfo = 4'hf;
        errReport.model_error_code = 16'h1234;
        errReport.archCode = 16'h0abc;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        access(mceb_pkg::ACC_READ, mceb_pkg::CAP_ADDR, 64'h0, 1'b0);
        chk("capability", rd, CAPV);
        access(mceb_pkg::ACC_WRITE, mceb_pkg::CAP_ADDR, 64'h0, 1'b1);
        access(mceb_pkg::ACC_WRITE, mceb_pkg::BANK0_CTL, 64'hffff_ffff_ffff_ffff, 1'b0);
        access(mceb_pkg::ACC_READ, mceb_pkg::BANK0_CTL, 64'h0, 1'b0);
        chk("control", rd, MASK);
        inject(1'b0, 6'h00, 1'b0);
        status("corrected", exp_st(1'b0, 1'b1, 1'b0, 15'h1));
        inject(1'b0, 6'h00, 1'b0);
        status("overflow", exp_st(1'b0, 1'b1, 1'b1, 15'h2));
        access(mceb_pkg::ACC_WRITE, mceb_pkg::BANK0_STATUS, 64'h1, 1'b1);
        status("refused", exp_st(1'b0, 1'b1, 1'b1, 15'h2));
        access(mceb_pkg::ACC_WRITE, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        status("cleared", 64'h0);
        inject(1'b1, 6'h3c, 1'b0);
        status("disabled", exp_st(1'b1, 1'b0, 1'b0, 15'h0));
        access(mceb_pkg::ACC_WRITE, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        inject(1'b1, 6'h01, 1'b1);
        inject(1'b0, 6'h00, 1'b0);
        status("kept", exp_st(1'b1, 1'b1, 1'b1, 15'h1));
        access(mceb_pkg::ACC_WRITE, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        // yellow log outranks a later green one
        errReport.threshold = mceb_pkg::THR_YELLOW;
        inject(1'b0, 6'h00, 1'b0);
        errReport.threshold = mceb_pkg::THR_GREEN;
        inject(1'b0, 6'h00, 1'b0);
        access(mceb_pkg::ACC_READ, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        chk("yellow kept", {62'h0, rd[54:53]}, {62'h0, mceb_pkg::THR_YELLOW});
        // error and zero write in one cycle: the new log survives
        @(negedge clk);
        errValid = 1'b1;
        acc = mceb_pkg::ACC_WRITE;
        addr = mceb_pkg::BANK0_STATUS;
        wdata = 64'h0;
        @(negedge clk);
        errValid = 1'b0;
        acc = mceb_pkg::ACC_IDLE;
        status("log beats clear", exp_st(1'b0, 1'b1, 1'b0, 15'h1));
        errReport.threshold = mceb_pkg::THR_RSVD;
        inject(1'b0, 6'h00, 1'b0);
        access(mceb_pkg::ACC_READ, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        chk("reserved colour", {62'h0, rd[54:53]}, {62'h0, mceb_pkg::THR_NONE});
        access(mceb_pkg::ACC_WRITE, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        access(mceb_pkg::ACC_READ, 32'h0000_0402, 64'h0, 1'b1);
        chk("unmapped", rd, 64'h0);
        // burst long enough to pass the top count bit
        @(negedge clk);
        errValid = 1'b1;
        repeat (16384) @(negedge clk);
        errValid = 1'b0;
        access(mceb_pkg::ACC_READ, mceb_pkg::BANK0_STATUS, 64'h0, 1'b0);
        chk("count", {49'h0, rd[52:38]}, {49'h0, 15'h4000});
        stop_test();
    end
endmodule
